// *** logic/lpm_pkg.sv ***
// Package with register offsets, field positions and reset values of the low-power mode block.
package lpm_pkg;
	// Register byte addresses on the Avalon-MM slave.
	localparam logic [3:0] LPM_ADDR_POWER_CONTROL = 4'h0;
	localparam logic [3:0] LPM_ADDR_OSC_CONTROL = 4'h4;
	localparam logic [3:0] LPM_ADDR_STATUS = 4'h8;
	localparam logic [3:0] LPM_ADDR_WATCHDOG = 4'hC;
	// Field positions in the power control register.
	localparam int LPM_BIT_IDLE = 0;
	localparam int LPM_BIT_STOP = 1;
	localparam int LPM_GF_LSB = 2;
	localparam int LPM_GF_MSB = 7;
	// Field positions in the oscillator control register.
	localparam int LPM_BIT_SUSPEND = 5;
	// Field positions in the watchdog control register.
	localparam int LPM_BIT_WD_ENABLE = 0;
	localparam int LPM_BIT_WD_LOCK = 1;
	// Reset values.
	localparam logic [5:0] LPM_GF_RESET = 6'h00;
	localparam logic [7:0] LPM_OSC_RESET = 8'h00;
	localparam logic LPM_WD_ENABLE_RESET = 1'b1;
	localparam logic LPM_WD_LOCK_RESET = 1'b0;
	// Default watchdog timeout in system clocks.
	localparam int LPM_WD_TIMEOUT = 65536;
	// Address the core fetches from after any reset.
	localparam logic [15:0] LPM_RESET_VECTOR = 16'h0000;
	// Power modes of the core.
	typedef enum logic [1:0] {
		LPM_RUN,
		LPM_IDLE,
		LPM_STOP,
		LPM_SUSPEND
	} lpm_mode_type;
endpackage : lpm_pkg

// *** logic/lpm_sync.sv ***
`timescale 1ns/1ns
// Two-flop synchroniser for a bundle of pin-side wake inputs.
module lpm_sync #(
	parameter int WIDTH = 2
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] first_reg;
		logic [WIDTH-1:0] second_reg;
	} lpm_sync_state_type;

	lpm_sync_state_type state_reg;
	lpm_sync_state_type state_next;

	// The first stage feeds only the second stage.
	always_comb begin
		state_next.first_reg = async_in;
		state_next.second_reg = state_reg.first_reg;
	end

	// Both stages clear on reset.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign sync_out = state_reg.second_reg;
endmodule : lpm_sync

// *** logic/lpm_control.sv ***
`timescale 1ns/1ns
// Low-power mode controller: idle, stop and suspend gating for the processor core.
// Function
// - Setting idle halts the core once the setting instruction retires.
// - Idle keeps registers and memory; peripheral clocks keep running.
// - Enabled interrupt or reset ends idle; interrupt clears idle bit.
// - Interrupt wake services the interrupt, then resumes after the idle instruction.
// - Reset ending idle runs normal reset sequence, fetch from 0x0000.
// - Enabled watchdog keeps counting in idle and resets; disable only if unlocked.
// - Stop halts core and internal oscillator; only missing-clock detector stays live.
// - Suspend halts core and oscillator, wakes on port match or comparator low.
// - Suspend bit sits in oscillator control; idle and stop in power control.
// - Stop exits only by reset, then fetch starts from 0x0000.
// - Stop is bit 1, idle bit 0 of power control; both read zero.
// - Suspend wake resumes after the setting instruction, interrupt serviced first.
module lpm_control
	import lpm_pkg::*;
#(
	parameter int WD_TIMEOUT = LPM_WD_TIMEOUT
) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic [3:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic CORE_RETIRE,
	input wire logic IRQ_PENDING,
	input wire logic EXT_RESET,
	input wire logic PORT_MATCH,
	input wire logic COMPARATOR_LOW,
	output logic CORE_CLK_EN,
	output logic INT_OSC_EN,
	output logic PERIPH_CLK_EN,
	output logic TIMERS_EN,
	output logic WAKE_IRQ,
	output logic CORE_RESET,
	output logic [15:0] RESET_PC,
	output logic WATCHDOG_RESET
);
	localparam int WD_W = $clog2(WD_TIMEOUT + 1);
	localparam logic [WD_W-1:0] WD_LAST = WD_W'(WD_TIMEOUT - 1);

	typedef struct packed {
		lpm_mode_type mode;
		logic idle_req;
		logic stop_req;
		logic suspend_req;
		logic [5:0] flags;
		logic [7:0] osc;
		logic wd_enable;
		logic wd_lock;
		logic [WD_W-1:0] wd_count;
		logic [31:0] rdata;
		logic ack;
		logic core_clk_en;
		logic int_osc_en;
		logic periph_clk_en;
		logic timers_en;
		logic wake_irq;
		logic core_reset;
		logic wd_reset;
	} lpm_state_type;

	lpm_state_type state_reg;
	lpm_state_type state_next;
	logic [1:0] wake_sync;

	// Pin-side wake sources cross two flops before any use.
	lpm_sync #(
		.WIDTH(2)
	) u_wake_sync (
		.clk(CLK),
		.resetn(RESETN),
		.async_in({PORT_MATCH, COMPARATOR_LOW}),
		.sync_out(wake_sync)
	);

	// Register read decode, shared by the read path.
	function automatic logic [31:0] read_word(input logic [3:0] addr, input lpm_state_type s);
		logic [31:0] w;
		w = 32'h0000_0000;
		unique case (addr)
			LPM_ADDR_POWER_CONTROL: begin
				w[LPM_GF_MSB:LPM_GF_LSB] = s.flags; // Mode bits stay zero.
			end
			LPM_ADDR_OSC_CONTROL: begin
				w[7:0] = s.osc;
			end
			LPM_ADDR_STATUS: begin
				w[1:0] = s.mode;
			end
			LPM_ADDR_WATCHDOG: begin
				w[LPM_BIT_WD_ENABLE] = s.wd_enable;
				w[LPM_BIT_WD_LOCK] = s.wd_lock;
			end
			default: begin
				w = 32'h0000_0000;
			end
		endcase
		return w;
	endfunction : read_word

	// Next-state logic for bus, mode machine and watchdog.
	always_comb begin
		logic wr;
		logic rst_evt;
		wr = 1'b0;
		rst_evt = 1'b0;
		state_next = state_reg;
		state_next.wake_irq = 1'b0;
		state_next.core_reset = 1'b0;
		state_next.wd_reset = 1'b0;
		// Every request waits exactly one cycle, so waitrequest is registered.
		state_next.ack = (AVS_READ || AVS_WRITE) && !state_reg.ack;
		// A write lands at the edge where the master sees waitrequest low, never earlier.
		wr = AVS_WRITE && state_reg.ack;
		if (AVS_READ && !state_reg.ack) begin
			state_next.rdata = read_word(AVS_ADDRESS, state_reg);
		end
		if (wr && AVS_BYTEENABLE[0]) begin
			unique case (AVS_ADDRESS)
				LPM_ADDR_POWER_CONTROL: begin
					state_next.flags = AVS_WRITEDATA[LPM_GF_MSB:LPM_GF_LSB];
					state_next.idle_req = AVS_WRITEDATA[LPM_BIT_IDLE];
					state_next.stop_req = AVS_WRITEDATA[LPM_BIT_STOP];
				end
				LPM_ADDR_OSC_CONTROL: begin
					state_next.osc = AVS_WRITEDATA[7:0];
					state_next.suspend_req = AVS_WRITEDATA[LPM_BIT_SUSPEND];
				end
				LPM_ADDR_WATCHDOG: begin
					// A locked watchdog ignores attempts to disable it.
					if (!state_reg.wd_lock) begin
						state_next.wd_enable = AVS_WRITEDATA[LPM_BIT_WD_ENABLE];
					end
					state_next.wd_lock = state_reg.wd_lock | AVS_WRITEDATA[LPM_BIT_WD_LOCK];
				end
				default: begin
				end
			endcase
		end
		// Watchdog runs on the free system clock, idle or not; stop and suspend silence it.
		if (state_reg.wd_enable && state_reg.mode != LPM_STOP
				&& state_reg.mode != LPM_SUSPEND) begin
			if (state_reg.wd_count == WD_LAST) begin
				state_next.wd_count = '0;
				state_next.wd_reset = 1'b1;
				rst_evt = 1'b1;
			end else begin
				state_next.wd_count = state_reg.wd_count + 1'b1;
			end
		end
		if (EXT_RESET) begin
			rst_evt = 1'b1;
		end
		// Mode machine; requests are applied only on the retire strobe.
		unique case (state_reg.mode)
			LPM_RUN: begin
				if (CORE_RETIRE && state_reg.stop_req) begin
					state_next.mode = LPM_STOP;
				end else if (CORE_RETIRE && state_reg.suspend_req) begin
					state_next.mode = LPM_SUSPEND;
				end else if (CORE_RETIRE && state_reg.idle_req) begin
					state_next.mode = LPM_IDLE;
				end
			end
			LPM_IDLE: begin
				if (IRQ_PENDING) begin
					// Interrupt wake; the core resumes and vectors to the handler.
					state_next.idle_req = 1'b0;
					state_next.wake_irq = 1'b1;
					state_next.mode = LPM_RUN;
				end
			end
			LPM_STOP: begin
				// Only a reset leaves stop.
			end
			LPM_SUSPEND: begin
				if (|wake_sync) begin
					state_next.suspend_req = 1'b0;
					state_next.osc[LPM_BIT_SUSPEND] = 1'b0;
					state_next.wake_irq = IRQ_PENDING;
					state_next.mode = LPM_RUN;
				end
			end
		endcase
		// An external or watchdog reset ends every mode and restarts the core at the vector.
		if (rst_evt) begin
			state_next.mode = LPM_RUN;
			state_next.idle_req = 1'b0;
			state_next.stop_req = 1'b0;
			state_next.suspend_req = 1'b0;
			state_next.flags = LPM_GF_RESET;
			state_next.osc = LPM_OSC_RESET;
			state_next.wd_enable = LPM_WD_ENABLE_RESET;
			state_next.wd_lock = LPM_WD_LOCK_RESET;
			state_next.wd_count = '0;
			state_next.core_reset = 1'b1;
		end
		// Core clock stops in every low mode; peripherals only in stop and suspend.
		state_next.core_clk_en = (state_next.mode == LPM_RUN);
		state_next.int_osc_en = (state_next.mode != LPM_STOP)
			&& (state_next.mode != LPM_SUSPEND);
		state_next.periph_clk_en = state_next.int_osc_en;
		state_next.timers_en = state_next.int_osc_en;
	end

	// One register stage holds all state outside the wake synchroniser.
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			state_reg <= '{mode: LPM_RUN, wd_enable: LPM_WD_ENABLE_RESET,
				core_clk_en: 1'b1, int_osc_en: 1'b1, periph_clk_en: 1'b1,
				timers_en: 1'b1, default: '0};
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs other than RESET_PC come straight from the state register.
	assign AVS_READDATA = state_reg.rdata;
	assign AVS_WAITREQUEST = !state_reg.ack;
	assign CORE_CLK_EN = state_reg.core_clk_en;
	assign INT_OSC_EN = state_reg.int_osc_en;
	assign PERIPH_CLK_EN = state_reg.periph_clk_en;
	assign TIMERS_EN = state_reg.timers_en;
	assign WAKE_IRQ = state_reg.wake_irq;
	assign CORE_RESET = state_reg.core_reset;
	assign RESET_PC = LPM_RESET_VECTOR; // Constant vector for every reset.
	assign WATCHDOG_RESET = state_reg.wd_reset;
endmodule : lpm_control

// *** verification/lpm_control_asserts.sv ***
// Port checker of the low-power mode controller.
`timescale 1ns/1ns
module lpm_control_asserts
	import lpm_pkg::*;
#(
	parameter int WD_TIMEOUT = 32
) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic [3:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	input wire logic CORE_RETIRE,
	input wire logic IRQ_PENDING,
	input wire logic EXT_RESET,
	input wire logic CORE_CLK_EN,
	input wire logic INT_OSC_EN,
	input wire logic PERIPH_CLK_EN,
	input wire logic TIMERS_EN,
	input wire logic WAKE_IRQ,
	input wire logic CORE_RESET,
	input wire logic WATCHDOG_RESET
);
	// One clock domain, so clock and reset are given once.
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	// An unanswered bus request, and the idle state with the oscillator still running.
	sequence s_req; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST; endsequence
	sequence s_idle; !CORE_CLK_EN && INT_OSC_EN; endsequence
	property p_ack; s_req |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST; endproperty
	a_ack: assert property (p_ack) else $error("bus answer wrong");
	property p_zero; s_req ##0 (AVS_READ && AVS_ADDRESS == LPM_ADDR_POWER_CONTROL)
		|=> AVS_READDATA[1:0] == 2'b00; endproperty
	a_zero: assert property (p_zero) else $error("mode bits read nonzero");
	property p_gate; $fell(CORE_CLK_EN) |-> $past(CORE_RETIRE); endproperty
	a_gate: assert property (p_gate) else $error("gating without retire");
	property p_wake; s_idle ##0 (IRQ_PENDING && !EXT_RESET) |=> WAKE_IRQ && CORE_CLK_EN; endproperty
	a_wake: assert property (p_wake) else $error("idle wake missed");
	property p_periph; s_idle |-> PERIPH_CLK_EN && TIMERS_EN; endproperty
	a_periph: assert property (p_periph) else $error("idle stopped peripherals");
	property p_halt; !INT_OSC_EN |-> !CORE_CLK_EN && !PERIPH_CLK_EN && !TIMERS_EN; endproperty
	a_halt: assert property (p_halt) else $error("halt incomplete");
	property p_rst; $rose(EXT_RESET) |-> ##[0:2] CORE_RESET; endproperty
	a_rst: assert property (p_rst) else $error("reset sequence missing");
	property p_wd; WATCHDOG_RESET |-> ##[0:2] CORE_CLK_EN; endproperty
	a_wd: assert property (p_wd) else $error("watchdog did not wake core");
endmodule : lpm_control_asserts

bind lpm_control lpm_control_asserts #(.WD_TIMEOUT(WD_TIMEOUT)) lpm_chk (.CLK, .RESETN,
	.AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_READDATA, .AVS_WAITREQUEST, .CORE_RETIRE,
	.IRQ_PENDING, .EXT_RESET, .CORE_CLK_EN, .INT_OSC_EN, .PERIPH_CLK_EN, .TIMERS_EN,
	.WAKE_IRQ, .CORE_RESET, .WATCHDOG_RESET);

// *** verification/lpm_core_model.sv ***
// Behavioural model of the processor core's retire strobe.
`timescale 1ns/1ns
module lpm_core_model (
	input wire logic step,
	input wire logic core_clk_en,
	output logic retire
);
	// A gated core retires nothing, so a step asked while halted is lost.
	assign retire = step && core_clk_en;
endmodule : lpm_core_model

// *** verification/lpm_control_tb.sv ***
// Self-checking testbench of the low-power mode controller.
`timescale 1ns/1ns
module lpm_control_tb
	import lpm_pkg::*;
;
	localparam int WD = 32;
	logic CLK = 1'b0;
	logic RESETN = 1'b0;
	logic [3:0] AVS_ADDRESS = 4'h0;
	logic AVS_READ = 1'b0;
	logic AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
	logic [3:0] AVS_BYTEENABLE = 4'hF;
	logic IRQ_PENDING = 1'b0, EXT_RESET = 1'b0, PORT_MATCH = 1'b0, COMPARATOR_LOW = 1'b0;
	logic step = 1'b0;
	logic [31:0] AVS_READDATA;
	logic [15:0] RESET_PC;
	logic AVS_WAITREQUEST, CORE_RETIRE, CORE_CLK_EN, INT_OSC_EN, PERIPH_CLK_EN, TIMERS_EN;
	logic WAKE_IRQ, CORE_RESET, WATCHDOG_RESET;
	logic [7:0] q;
	int n_mismatch = 0;
	int comparisons = 0;
	lpm_control #(.WD_TIMEOUT(WD)) lpm_control_inst (.CLK, .RESETN, .AVS_ADDRESS, .AVS_READ,
		.AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .CORE_RETIRE,
		.IRQ_PENDING, .EXT_RESET, .PORT_MATCH, .COMPARATOR_LOW, .CORE_CLK_EN, .INT_OSC_EN,
		.PERIPH_CLK_EN, .TIMERS_EN, .WAKE_IRQ, .CORE_RESET, .RESET_PC, .WATCHDOG_RESET);
	lpm_core_model lpm_core_model_inst (.step(step), .core_clk_en(CORE_CLK_EN), .retire(CORE_RETIRE));
	// Free-running 10 MHz system clock.
	initial begin
		forever #50 CLK = ~CLK;
	end
	task automatic stop_test();
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [7:0] exp, input logic [7:0] got, input string nm);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// One bus access; the request stands until waitrequest is seen low, with no limit of its own.
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
		AVS_ADDRESS <= a;
		AVS_WRITE <= wr;
		AVS_READ <= !wr;
		AVS_WRITEDATA <= {24'h00_0000, d};
		do begin
			@(negedge CLK);
		end while (AVS_WAITREQUEST !== 1'b0);
		q = AVS_READDATA[7:0];
		@(posedge CLK);
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
		@(posedge CLK);
	endtask : bus
	task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string nm);
		bus(1'b0, a, 8'h00);
		chk(exp, q, nm);
	endtask : rd
	// Enables in the order core, oscillator, peripherals, timers.
	task automatic look(input logic [3:0] exp, input string nm);
		@(negedge CLK);
		chk({4'h0, exp}, {4'h0, CORE_CLK_EN, INT_OSC_EN, PERIPH_CLK_EN, TIMERS_EN}, nm);
		@(posedge CLK);
	endtask : look
	task automatic await(ref logic sig, input int lim, input string nm);
		int n;
		n = 0;
		do begin
			@(negedge CLK);
			n++;
		end while (sig !== 1'b1 && n < lim);
		chk(8'h01, {7'h00, sig}, nm);
		@(posedge CLK);
	endtask : await
	task automatic retire();
		step <= 1'b1;
		@(posedge CLK);
		step <= 1'b0;
		@(posedge CLK);
	endtask : retire
	// Reset values first, then flags, then an unmapped place.
	task automatic t_regs();
		rd(LPM_ADDR_WATCHDOG, 8'h01, "wd reset");
		bus(1'b1, LPM_ADDR_WATCHDOG, 8'h00);
		rd(LPM_ADDR_POWER_CONTROL, 8'h00, "power_control_register reset");
		rd(LPM_ADDR_OSC_CONTROL, 8'h00, "osc reset");
		AVS_BYTEENABLE <= 4'hE;
		bus(1'b1, LPM_ADDR_POWER_CONTROL, 8'hFC);
		rd(LPM_ADDR_POWER_CONTROL, 8'h00, "lane off");
		AVS_BYTEENABLE <= 4'hF;
		bus(1'b1, LPM_ADDR_POWER_CONTROL, 8'hFC);
		rd(LPM_ADDR_POWER_CONTROL, 8'hFC, "power_control_register flags");
		bus(1'b1, 4'h2, 8'hFF);
		rd(4'h2, 8'h00, "unmapped");
	endtask : t_regs
	task automatic t_idle();
		bus(1'b1, LPM_ADDR_POWER_CONTROL, 8'h01);
		rd(LPM_ADDR_POWER_CONTROL, 8'h00, "idle bit");
		look(4'hF, "no retire");
		retire();
		look(4'h7, "idle gating");
		rd(LPM_ADDR_STATUS, 8'h01, "idle status");
		IRQ_PENDING <= 1'b1;
		await(WAKE_IRQ, 4, "idle wake");
		IRQ_PENDING <= 1'b0;
		look(4'hF, "idle resumed");
	endtask : t_idle
	// Interrupt and port-match wakes must not end stop mode.
	task automatic t_stop();
		bus(1'b1, LPM_ADDR_POWER_CONTROL, 8'h02);
		retire();
		look(4'h0, "stop gating");
		rd(LPM_ADDR_STATUS, 8'h02, "stop status");
		{IRQ_PENDING, PORT_MATCH} <= 2'b11;
		repeat (6) @(posedge CLK);
		look(4'h0, "stop holds");
		{IRQ_PENDING, PORT_MATCH, EXT_RESET} <= 3'b001;
		await(CORE_RESET, 4, "stop reset");
		EXT_RESET <= 1'b0;
		chk(8'h01, {7'h00, RESET_PC === 16'h0000}, "vector");
		bus(1'b1, LPM_ADDR_WATCHDOG, 8'h00);
		look(4'hF, "after reset");
	endtask : t_stop
	task automatic t_susp();
		for (int i = 0; i < 2; i++) begin
			bus(1'b1, LPM_ADDR_OSC_CONTROL, 8'h20);
			rd(LPM_ADDR_OSC_CONTROL, 8'h20, "suspend bit");
			retire();
			look(4'h0, "suspend gating");
			{COMPARATOR_LOW, PORT_MATCH} <= 2'b01 << i;
			IRQ_PENDING <= (i == 1);
			if (i == 1) begin
				await(WAKE_IRQ, 8, "suspend irq");
			end else begin
				await(CORE_CLK_EN, 8, "suspend wake");
			end
			{COMPARATOR_LOW, PORT_MATCH} <= 2'b00;
			IRQ_PENDING <= 1'b0;
			look(4'hF, "suspend run");
		end
	endtask : t_susp
	// A locked watchdog cannot be disabled and ends idle.
	task automatic t_wd();
		bus(1'b1, LPM_ADDR_POWER_CONTROL, 8'h01);
		bus(1'b1, LPM_ADDR_WATCHDOG, 8'h03);
		bus(1'b1, LPM_ADDR_WATCHDOG, 8'h00);
		retire();
		look(4'h7, "wd idle");
		rd(LPM_ADDR_WATCHDOG, 8'h03, "wd locked");
		await(WATCHDOG_RESET, 3 * WD, "wd expiry");
		look(4'hF, "wd wake");
	endtask : t_wd
	initial begin
		repeat (6) @(posedge CLK);
		RESETN <= 1'b1;
		@(posedge CLK);
		t_regs();
		t_idle();
		t_stop();
		t_susp();
		t_wd();
		stop_test();
	end
	// Cuts a hang short well beyond the roughly 150 cycles the run needs.
	initial begin
		repeat (3000) @(posedge CLK);
		n_mismatch++;
		stop_test();
	end
endmodule : lpm_control_tb
